// ==== logic/debug_firmware_command_engine.sv ====
// Firmware command engine of the single-wire background debug port
// How it works
// R1 - firmware commands only in active debug mode
// R2 - user execution halted while debug active
// R3 - debug window mapped when debug mode entered
// R4 - opcodes 63..67 return PC, D, X, Y, SP
// R5 - opcodes 43..47 load PC, D, X, Y, SP
// R6 - 62 adds two to X, reads there
// R7 - 42 adds two to X, writes there
// R8 - 08 resumes, acknowledge on leaving debug
// R9 - 0C resumes, acknowledge on debug re-entry
// R10 - 10 runs one instruction, acknowledges on return
// R11 - 18 behaves exactly like 08
// R12 - reads acknowledge ready data, writes when done
// R13 - frame is opcode then optional 16-bit word
// R14 - byte data upper for even, lower odd
// R15 - debug window reached, firmware never written
// R16 - stop disables acknowledge; wait/stop cancels 0C
// R17 - misaligned word access uses even address
// R18 - host waits 150 clocks for hardware access
// R19 - host waits 48 clocks before read data
// R20 - host waits 36 clocks after write data
// R21 - host waits 76 clocks after resume/step
// R22 - host should prefer acknowledge over fixed delays
// R23 - each bit starts with host falling edge
// R24 - MSB first, 16 target clocks per bit
// R25 - acknowledge low 16 clocks, 32 clocks after
// R26 - D5 enables acknowledge and acks, D6 disables
// R27 - unknown opcodes ignored, no acknowledge
`timescale 1ns/1ns
module debug_firmware_command_engine
  import dbg_cmd_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  input wire logic i_sys_clk,             // 20 MHz target clock
  input wire logic i_rst_n,               // Async reset, active low
  input wire logic i_clk_en,              // Freezes all state when low
  input wire logic i_debug_serial_pin,    // Level on the debug serial pin
  input wire logic i_enter_debug,         // Pulse: CPU enters active debug
  input wire logic [15:0] i_user_pc,      // CPU program counter at entry
  input wire logic i_step_done,           // Pulse: stepped instruction done
  input wire logic i_cpu_wait_stop,       // CPU executed wait or stop
  input wire logic i_sys_stop,            // System stop mode
  output logic o_debug_serial_pin_out,    // Pin drive level
  output logic o_debug_serial_pin_oe,     // Pin driven while high
  output logic o_debug_active,            // Active debug mode
  output logic o_map_window,              // Debug window in memory map
  output logic o_user_run,                // User code may execute
  output logic o_step_req,                // Pulse: run one instruction
  output logic o_ack_en,                  // Acknowledge enabled
  output logic [15:0] o_prog_counter,     // Program counter
  output logic [15:0] o_acc_d,            // D accumulator
  output logic [15:0] o_idx_x,            // X index
  output logic [15:0] o_idx_y,            // Y index
  output logic [15:0] o_stack_ptr         // Stack pointer
);
  state_e state_q, state_d, after_q, after_d;
  logic [7:0] op_q, op_d;
  logic [15:0] shreg_q, shreg_d;
  logic [4:0] tick_q, tick_d, nbit_q, nbit_d;
  logic [9:0] idle_q, idle_d;
  logic [5:0] gap_q, gap_d;
  logic in_bit_q, in_bit_d, pin_prev_q;
  logic active_q, active_d, run_q, run_d, step_q, step_d;
  logic ack_en_q, ack_en_d, ack_pend_q, ack_pend_d;
  logic out_q, out_d, oe_q, oe_d;
  logic [15:0] pc_q, pc_d, d_q, d_d, x_q, x_d, y_q, y_d, sp_q, sp_d;
  logic fall, bit_end, frame_end, rx_mode, tx_mode, ack_ok;
  logic [4:0] tnext;

  dbg_mem_if #(.AW(MEM_AW)) mbus ();

  dbg_word_mem #(.AW(MEM_AW)) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_clk_en(i_clk_en),
    .bus(mbus)
  );

  function automatic logic in_window(input logic [15:0] a);
    return a >= DBG_WIN_BASE;
  endfunction

  // Debug window is byte wide: status byte placed by address parity
  function automatic logic [15:0] window_word(input logic [15:0] a, input logic [7:0] b);
    return a[0] ? {8'h00, b} : {b, 8'h00}; // see R14
  endfunction

  assign fall = pin_prev_q & ~i_debug_serial_pin; // see R23
  assign rx_mode = (state_q == S_OPC) || (state_q == S_DATA);
  assign tx_mode = (state_q == S_TX);
  assign bit_end = in_bit_q && (tick_q == 5'(BIT_TICKS - 1));
  assign frame_end = bit_end && (nbit_q == 5'h01);
  assign tnext = tick_q + 5'h01;
  assign ack_ok = ack_en_q && !i_sys_stop; // see R16
  // Word access drops the address LSB
  assign mbus.addr = x_q[MEM_AW:1]; // see R17
  assign mbus.wdata = shreg_q;
  assign mbus.we = (state_q == S_MEMWR) && !in_window(x_q); // see R15

  always_comb begin
    state_d = state_q;
    after_d = after_q;
    op_d = op_q;
    shreg_d = shreg_q;
    tick_d = tick_q;
    nbit_d = nbit_q;
    idle_d = idle_q;
    gap_d = (gap_q < 6'(ACK_GAP_TICKS)) ? gap_q + 6'h01 : gap_q;
    in_bit_d = in_bit_q;
    active_d = active_q;
    run_d = run_q;
    step_d = 1'b0;
    ack_en_d = ack_en_q;
    ack_pend_d = ack_pend_q;
    out_d = 1'b1;
    oe_d = 1'b0;
    pc_d = pc_q;
    d_d = d_q;
    x_d = x_q;
    y_d = y_q;
    sp_d = sp_q;
    // Bit engine: host edge opens each bit time of 16 ticks
    if (rx_mode || tx_mode) begin
      if (!in_bit_q) begin
        idle_d = idle_q + 10'h001;
        if (fall) begin
          in_bit_d = 1'b1;
          tick_d = '0;
          idle_d = '0;
        end else if (idle_q == 10'(TIMEOUT_TICKS - 1)) begin
          state_d = S_OPC;
          nbit_d = 5'(OPC_BITS);
          idle_d = '0;
        end
      end else begin
        tick_d = tnext;
        if (rx_mode && tick_q == 5'(SAMPLE_TICK)) begin
          shreg_d = {shreg_q[14:0], i_debug_serial_pin}; // see R24
        end
        if (tx_mode) begin
          if (!shreg_q[15] && tnext < 5'(LOW0_TICKS)) begin
            oe_d = 1'b1;
            out_d = 1'b0;
          end else if (tnext == (shreg_q[15] ? 5'(SPEEDUP_TICK) : 5'(LOW0_TICKS))) begin
            oe_d = 1'b1;
          end
        end
        if (bit_end) begin
          in_bit_d = 1'b0;
          nbit_d = nbit_q - 5'h01;
          if (tx_mode) begin
            shreg_d = {shreg_q[14:0], 1'b0}; // see R24
          end
        end
      end
    end
    if (frame_end) begin
      gap_d = '0;
    end
    case (state_q)
      S_OPC: begin
        if (frame_end) begin
          op_d = shreg_q[7:0];
          nbit_d = 5'(OPC_BITS);
          if (shreg_q[7:0] == OP_ACK_ON) begin
            ack_en_d = 1'b1; // see R26
            ack_pend_d = !i_sys_stop;
            after_d = S_OPC;
            state_d = S_GAP;
          end else if (shreg_q[7:0] == OP_ACK_OFF) begin
            ack_en_d = 1'b0; // see R26
          end else if (active_q) begin // see R1
            case (shreg_q[7:0])
              OP_READ_NEXT, OP_FETCH_PC, OP_FETCH_D, OP_FETCH_X, OP_FETCH_Y,
              OP_FETCH_SP: begin
                state_d = S_EXEC;
              end
              OP_WRITE_NEXT, OP_LOAD_PC, OP_LOAD_D, OP_LOAD_X, OP_LOAD_Y,
              OP_LOAD_SP: begin
                state_d = S_DATA; // see R13
                nbit_d = 5'(WORD_BITS);
              end
              OP_GO, OP_LEGACY_TAG_RESUME: begin // see R11
                ack_pend_d = ack_ok;
                after_d = S_RUN;
                state_d = S_GAP; // see R8
              end
              OP_GO_UNTIL: begin
                ack_pend_d = ack_ok; // see R9
                active_d = 1'b0;
                run_d = 1'b1;
                state_d = S_RUN;
              end
              OP_SINGLE_STEP: begin
                ack_pend_d = ack_ok;
                active_d = 1'b0;
                run_d = 1'b1;
                step_d = 1'b1; // see R10
                state_d = S_STEP;
              end
              default: begin
                state_d = S_OPC; // see R27
              end
            endcase
          end
        end
      end
      S_DATA: begin
        if (frame_end) begin
          nbit_d = 5'(OPC_BITS);
          ack_pend_d = ack_ok;
          after_d = S_OPC;
          state_d = S_GAP;
          case (op_q)
            OP_LOAD_PC: pc_d = shreg_q; // see R5
            OP_LOAD_D: d_d = shreg_q;
            OP_LOAD_X: x_d = shreg_q;
            OP_LOAD_Y: y_d = shreg_q;
            OP_LOAD_SP: sp_d = shreg_q;
            default: begin
              x_d = x_q + X_STEP; // see R7
              state_d = S_MEMWR;
            end
          endcase
        end
      end
      S_EXEC: begin
        ack_pend_d = ack_ok; // see R12
        after_d = S_TX;
        state_d = S_GAP;
        case (op_q)
          OP_FETCH_PC: shreg_d = pc_q; // see R4
          OP_FETCH_D: shreg_d = d_q;
          OP_FETCH_X: shreg_d = x_q;
          OP_FETCH_Y: shreg_d = y_q;
          OP_FETCH_SP: shreg_d = sp_q;
          default: begin
            x_d = x_q + X_STEP; // see R6
            state_d = S_MEMRD;
          end
        endcase
      end
      S_MEMRD: state_d = S_MEMWT;
      S_MEMWT: begin
        shreg_d = in_window(x_q) ?
          window_word(x_q, {6'h00, ack_en_q, active_q}) : mbus.rdata; // see R15
        state_d = S_GAP;
      end
      S_MEMWR: state_d = S_GAP; // see R12
      S_GAP: begin
        if (gap_q >= 6'(ACK_GAP_TICKS)) begin // see R25
          if (after_q == S_RUN) begin
            active_d = 1'b0; // see R8
            run_d = 1'b1;
          end
          if (ack_pend_q) begin
            ack_pend_d = 1'b0;
            state_d = S_ACK;
            tick_d = '0;
            oe_d = 1'b1;
            out_d = 1'b0;
          end else begin
            state_d = after_q;
          end
        end
      end
      S_ACK: begin
        tick_d = tnext;
        oe_d = 1'b1;
        out_d = 1'b0;
        if (tick_q == 5'(ACK_LOW_TICKS - 1)) begin
          out_d = 1'b1; // see R25
          state_d = S_ACK_HI;
        end
      end
      S_ACK_HI: state_d = after_q;
      S_TX: begin
        if (frame_end) begin
          state_d = S_OPC;
          nbit_d = 5'(OPC_BITS);
        end
      end
      S_RUN: begin
        if (i_cpu_wait_stop) begin
          ack_pend_d = 1'b0; // see R16
        end
        if (i_enter_debug) begin
          active_d = 1'b1; // see R3
          run_d = 1'b0;
          pc_d = i_user_pc;
          after_d = S_OPC;
          nbit_d = 5'(OPC_BITS);
          in_bit_d = 1'b0;
          state_d = (ack_pend_q && !i_cpu_wait_stop) ? S_GAP : S_OPC; // see R9
        end
      end
      S_STEP: begin
        if (i_step_done) begin
          active_d = 1'b1; // see R10
          run_d = 1'b0;
          pc_d = i_user_pc;
          after_d = S_OPC;
          nbit_d = 5'(OPC_BITS);
          in_bit_d = 1'b0;
          state_d = S_GAP;
        end
      end
      default: state_d = S_OPC;
    endcase
    if (state_d == S_TX && state_q != S_TX) begin
      nbit_d = 5'(WORD_BITS);
      in_bit_d = 1'b0;
    end
    if (active_d) begin
      run_d = 1'b0; // see R2
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= S_RUN;
      after_q <= S_OPC;
      op_q <= '0;
      shreg_q <= '0;
      tick_q <= '0;
      nbit_q <= 5'(OPC_BITS);
      idle_q <= '0;
      gap_q <= '0;
      in_bit_q <= 1'b0;
      pin_prev_q <= 1'b1;
      active_q <= 1'b0;
      run_q <= 1'b1;
      step_q <= 1'b0;
      ack_en_q <= 1'b0;
      ack_pend_q <= 1'b0;
      out_q <= 1'b1;
      oe_q <= 1'b0;
      pc_q <= REG_RESET;
      d_q <= REG_RESET;
      x_q <= REG_RESET;
      y_q <= REG_RESET;
      sp_q <= REG_RESET;
    end else if (i_clk_en) begin
      state_q <= state_d;
      after_q <= after_d;
      op_q <= op_d;
      shreg_q <= shreg_d;
      tick_q <= tick_d;
      nbit_q <= nbit_d;
      idle_q <= idle_d;
      gap_q <= gap_d;
      in_bit_q <= in_bit_d;
      pin_prev_q <= i_debug_serial_pin;
      active_q <= active_d;
      run_q <= run_d;
      step_q <= step_d;
      ack_en_q <= ack_en_d;
      ack_pend_q <= ack_pend_d;
      out_q <= out_d;
      oe_q <= oe_d;
      pc_q <= pc_d;
      d_q <= d_d;
      x_q <= x_d;
      y_q <= y_d;
      sp_q <= sp_d;
    end
  end

  assign o_debug_serial_pin_out = out_q;
  assign o_debug_serial_pin_oe = oe_q;
  assign o_debug_active = active_q;
  assign o_map_window = active_q; // see R3
  assign o_user_run = run_q;
  assign o_step_req = step_q;
  assign o_ack_en = ack_en_q;
  assign o_prog_counter = pc_q;
  assign o_acc_d = d_q;
  assign o_idx_x = x_q;
  assign o_idx_y = y_q;
  assign o_stack_ptr = sp_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n || !i_clk_en);

  sequence ack_low_half;
    (oe_q && !out_q) [*8];
  endsequence

  a_exec_needs_active: assert property (state_q == S_EXEC |-> active_q) // see R1
    else $error("firmware command executed outside debug mode");
  a_user_suspended: assert property (active_q |-> !run_q) // see R2
    else $error("user code runs in debug mode");
  a_fetch_pc_word: assert property ( // see R4
    state_q == S_EXEC && op_q == OP_FETCH_PC |=> shreg_q == $past(pc_q))
    else $error("program counter not returned");
  a_block_read_step: assert property ( // see R6
    state_q == S_EXEC && op_q == OP_READ_NEXT |=> x_q == $past(x_q) + X_STEP)
    else $error("block read did not advance index by two");
  a_window_no_write: assert property (in_window(x_q) |-> !mbus.we) // see R15
    else $error("write reached debug window");
  a_ack_after_gap: assert property ( // see R25
    state_q == S_GAP && state_d == S_ACK |-> gap_q >= 6'(ACK_GAP_TICKS))
    else $error("acknowledge too early");
  a_ack_low_len: assert property ( // see R25
    state_q == S_GAP && state_d == S_ACK |=>
    ack_low_half ##1 ack_low_half ##1 (oe_q && out_q))
    else $error("acknowledge low pulse too short");
  a_unknown_no_ack: assert property ( // see R27
    state_q == S_OPC && frame_end && active_q && shreg_q[7:0] == 8'hff
    |=> state_q == S_OPC && !oe_q)
    else $error("unknown opcode not ignored");
  a_step_return: assert property ( // see R10
    state_q == S_STEP && i_step_done |=> active_q && state_q == S_GAP)
    else $error("single step did not return to debug");
endmodule

// ==== logic/dbg_cmd_pkg.sv ====
// Constants shared by the debug firmware command engine and its test bench
package dbg_cmd_pkg;
  localparam int WORD_W = 16;
  localparam int OPC_BITS = 8;
  localparam int WORD_BITS = 16;
  // Serial bit timing in target clock cycles
  localparam int BIT_TICKS = 16;
  localparam int SAMPLE_TICK = 10;
  localparam int SPEEDUP_TICK = 7;
  localparam int LOW0_TICKS = 13;
  localparam int ACK_LOW_TICKS = 16;
  localparam int ACK_GAP_TICKS = 32;
  localparam int TIMEOUT_TICKS = 512;
  // Firmware window and block access stride
  localparam logic [17:0] FW_MAP_BASE = 18'h3ff00;
  localparam logic [15:0] DBG_WIN_BASE = 16'hff00;
  localparam logic [15:0] X_STEP = 16'h0002;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Opcodes
  localparam logic [7:0] OP_READ_NEXT = 8'h62;
  localparam logic [7:0] OP_FETCH_PC = 8'h63;
  localparam logic [7:0] OP_FETCH_D = 8'h64;
  localparam logic [7:0] OP_FETCH_X = 8'h65;
  localparam logic [7:0] OP_FETCH_Y = 8'h66;
  localparam logic [7:0] OP_FETCH_SP = 8'h67;
  localparam logic [7:0] OP_WRITE_NEXT = 8'h42;
  localparam logic [7:0] OP_LOAD_PC = 8'h43;
  localparam logic [7:0] OP_LOAD_D = 8'h44;
  localparam logic [7:0] OP_LOAD_X = 8'h45;
  localparam logic [7:0] OP_LOAD_Y = 8'h46;
  localparam logic [7:0] OP_LOAD_SP = 8'h47;
  localparam logic [7:0] OP_GO = 8'h08;
  localparam logic [7:0] OP_GO_UNTIL = 8'h0c;
  localparam logic [7:0] OP_SINGLE_STEP = 8'h10;
  localparam logic [7:0] OP_LEGACY_TAG_RESUME = 8'h18;
  localparam logic [7:0] OP_ACK_ON = 8'hd5;
  localparam logic [7:0] OP_ACK_OFF = 8'hd6;
  typedef enum logic [3:0] {
    S_OPC = 4'b0000,
    S_DATA = 4'b0001,
    S_EXEC = 4'b0010,
    S_MEMRD = 4'b0011,
    S_MEMWT = 4'b0100,
    S_MEMWR = 4'b0101,
    S_GAP = 4'b0110,
    S_ACK = 4'b0111,
    S_ACK_HI = 4'b1000,
    S_TX = 4'b1001,
    S_RUN = 4'b1010,
    S_STEP = 4'b1011
  } state_e;
endpackage

// ==== logic/dbg_mem_if.sv ====
// Word memory port between the command engine and its memory
`timescale 1ns/1ns
interface dbg_mem_if #(parameter int AW = 8) ();
  logic we;
  logic [AW-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ==== logic/dbg_word_mem.sv ====
// Small word memory with registered read data
`timescale 1ns/1ns
module dbg_word_mem #(
  parameter int AW = 8
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_clk_en,  // Clock enable
  dbg_mem_if.mem bus          // Memory port
);
  logic [15:0] mem_q [0:(1<<AW)-1];
  logic [15:0] rdata_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en) begin
      if (bus.we) begin
        mem_q[bus.addr] <= bus.wdata;
      end
      rdata_q <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule

// ==== test/dbg_host_pod.sv ====
// Host pod model that drives and reads the single-wire debug pin
`timescale 1ns/1ns
module dbg_host_pod (
  input wire logic i_sys_clk, // Shared target clock
  input wire logic i_pin,     // Resolved pin level, pulled high
  output logic o_drive_low    // Host pulls the pin low
);
  initial o_drive_low = 1'b0;

  // Every bit starts with a pulled-low edge; one bit per 18 cycles
  task automatic send_bits(input logic [15:0] v, input int n);
    int hold;
    for (int i = n - 1; i >= 0; i--) begin
      hold = v[i] ? 4 : 13;
      @(negedge i_sys_clk) o_drive_low = 1'b1;
      repeat (hold) @(negedge i_sys_clk);
      o_drive_low = 1'b0;
      repeat (17 - hold) @(negedge i_sys_clk);
    end
  endtask

  // Release before the device speedup, sample about ten cycles in
  task automatic recv_bits(output logic [15:0] v);
    v = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      @(negedge i_sys_clk) o_drive_low = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      o_drive_low = 1'b0;
      repeat (8) @(negedge i_sys_clk);
      v[i] = i_pin;
      repeat (7) @(negedge i_sys_clk);
    end
  endtask

  // Waits for an acknowledge pulse; dly is -1 when none came
  task automatic get_ack(input int lim, output int dly, output int low);
    dly = -1;
    low = 0;
    for (int c = 0; c < lim && dly < 0; c++) begin
      @(negedge i_sys_clk);
      if (i_pin === 1'b0) dly = c;
    end
    while (dly >= 0 && i_pin === 1'b0 && low < 40) begin
      low++;
      @(negedge i_sys_clk);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
endmodule

// ==== test/debug_firmware_command_engine_test.sv ====
// Self-checking bench for the debug firmware command engine
`timescale 1ns/1ns
module debug_firmware_command_engine_test import dbg_cmd_pkg::*; ();
  typedef struct {
    logic [7:0] ld;
    logic [7:0] fe;
    logic [15:0] val;
  } row_s;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic enter = 1'b0;
  logic step_done = 1'b0;
  logic wait_stop = 1'b0;
  logic sys_stop = 1'b0;
  logic [15:0] user_pc = 16'h0000;
  logic pod_low;
  wire logic pin;
  logic pin_out, pin_oe, active, map, run, step_req, ack_en;
  logic [15:0] pc, d, x, y, sp, got;
  logic [15:0] regs [5];
  int mismatches = 0;
  int samples_checked = 0;
  int steps = 0;
  int s0;
  logic [7:0] go_ops [2] = '{OP_GO, OP_LEGACY_TAG_RESUME};
  row_s rows [5] = '{
    '{OP_LOAD_PC, OP_FETCH_PC, 16'h1357},
    '{OP_LOAD_D, OP_FETCH_D, 16'h8001},
    '{OP_LOAD_X, OP_FETCH_X, 16'hfffe},
    '{OP_LOAD_Y, OP_FETCH_Y, 16'h00ff},
    '{OP_LOAD_SP, OP_FETCH_SP, 16'h7ff0}
  };

  // Open-drain line with pull-up
  assign pin = ~pod_low & (pin_oe ? pin_out : 1'b1);
  always_comb regs = '{pc, d, x, y, sp};

  debug_firmware_command_engine #(.MEM_AW(8)) debug_firmware_command_engine_i (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
    .i_debug_serial_pin(pin), .i_enter_debug(enter), .i_user_pc(user_pc),
    .i_step_done(step_done), .i_cpu_wait_stop(wait_stop), .i_sys_stop(sys_stop),
    .o_debug_serial_pin_out(pin_out), .o_debug_serial_pin_oe(pin_oe),
    .o_debug_active(active), .o_map_window(map), .o_user_run(run),
    .o_step_req(step_req), .o_ack_en(ack_en), .o_prog_counter(pc),
    .o_acc_d(d), .o_idx_x(x), .o_idx_y(y), .o_stack_ptr(sp)
  );

  dbg_host_pod dbg_host_pod_i (.i_sys_clk(sys_clk), .i_pin(pin), .o_drive_low(pod_low));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (step_req === 1'b1) steps++;
  end

  function automatic logic [15:0] flags();
    return {10'h000, pin_out, pin_oe, active, map, run, ack_en};
  endfunction

  task automatic check_word(input logic [15:0] got_v, input logic [15:0] exp_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic check_bit(input logic got_b, input logic exp_b);
    check_word({15'h0000, got_b}, {15'h0000, exp_b});
  endtask

  task automatic end_test(input string name);
    $display("Test %s done", name);
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic expect_ack(input logic want, input int mn);
    int dly;
    int low;
    dbg_host_pod_i.get_ack(want ? 400 : 150, dly, low);
    check_bit(dly >= mn, want);
    if (want) check_word(16'(low), 16'h0010);
  endtask

  task automatic send_op(input logic [7:0] op);
    dbg_host_pod_i.send_bits({8'h00, op}, 8);
  endtask

  task automatic load(input logic [7:0] op, input logic [15:0] v);
    send_op(op);
    dbg_host_pod_i.send_bits(v, 16);
    if (ack_en === 1'b1) expect_ack(1'b1, 30);
    else dbg_host_pod_i.idle(36);
  endtask

  task automatic fetch(input logic [7:0] op, output logic [15:0] v);
    send_op(op);
    if (ack_en === 1'b1) expect_ack(1'b1, 30);
    else dbg_host_pod_i.idle(48);
    dbg_host_pod_i.recv_bits(v);
  endtask

  // which: 0 debug entry, 1 step finished, 2 wait or stop
  task automatic pulse(input int which, input logic [15:0] v);
    @(negedge sys_clk);
    user_pc = v;
    enter = (which == 0);
    step_done = (which == 1);
    wait_stop = (which == 2);
    @(negedge sys_clk);
    enter = 1'b0;
    step_done = 1'b0;
    wait_stop = 1'b0;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    check_word(flags(), 16'h0022);
    check_word(pc | d | x | y | sp, 16'h0000);
    end_test("reset");
    load(OP_LOAD_X, 16'h4321);
    check_word(x, 16'h0000);
    end_test("inactive");
    pulse(0, 16'h1234);
    check_word(flags(), 16'h002c);
    check_word(pc, 16'h1234);
    end_test("entry");
    for (int k = 0; k < 5; k++) begin
      load(rows[k].ld, rows[k].val);
      check_word(regs[k], rows[k].val);
      fetch(rows[k].fe, got);
      check_word(got, rows[k].val);
    end
    end_test("registers");
    send_op(OP_ACK_ON);
    expect_ack(1'b1, 30);
    check_bit(ack_en, 1'b1);
    load(OP_LOAD_X, 16'h0010);
    load(OP_WRITE_NEXT, 16'hbeef);
    check_word(x, 16'h0012);
    load(OP_LOAD_X, 16'h0010);
    fetch(OP_READ_NEXT, got);
    check_word(got, 16'hbeef);
    check_word(x, 16'h0012);
    end_test("block");
    load(OP_LOAD_X, 16'h00fe);
    load(OP_WRITE_NEXT, 16'h1111);
    load(OP_LOAD_X, 16'hfefe);
    load(OP_WRITE_NEXT, 16'h5a5a);
    load(OP_LOAD_X, 16'hfefe);
    fetch(OP_READ_NEXT, got);
    check_word(got, 16'h0300);
    load(OP_LOAD_X, 16'hfeff);
    fetch(OP_READ_NEXT, got);
    check_word(got, 16'h0003);
    load(OP_LOAD_X, 16'h00fe);
    fetch(OP_READ_NEXT, got);
    check_word(got, 16'h1111);
    end_test("window");
    send_op(8'hff);
    expect_ack(1'b0, 0);
    check_word(x, 16'h0100);
    sys_stop = 1'b1;
    send_op(OP_LOAD_D);
    dbg_host_pod_i.send_bits(16'h7777, 16);
    expect_ack(1'b0, 0);
    sys_stop = 1'b0;
    end_test("ignored");
    s0 = steps;
    send_op(OP_SINGLE_STEP);
    expect_ack(1'b0, 0);
    check_word(16'(steps - s0), 16'h0001);
    pulse(1, 16'h4000);
    expect_ack(1'b1, 0);
    check_word(pc, 16'h4000);
    check_bit(active, 1'b1);
    end_test("step");
    for (int k = 0; k < 2; k++) begin
      send_op(go_ops[k]);
      expect_ack(1'b1, 30);
      check_word(flags() & 16'h000a, 16'h0002);
      dbg_host_pod_i.idle(76);
      pulse(0, 16'h2000);
      dbg_host_pod_i.idle(80);
    end
    end_test("resume");
    send_op(OP_GO_UNTIL);
    expect_ack(1'b0, 0);
    check_bit(active, 1'b0);
    pulse(0, 16'h2100);
    expect_ack(1'b1, 0);
    send_op(OP_GO_UNTIL);
    dbg_host_pod_i.idle(76);
    pulse(2, 16'h0000);
    pulse(0, 16'h2200);
    expect_ack(1'b0, 0);
    end_test("until");
    send_op(OP_ACK_OFF);
    expect_ack(1'b0, 0);
    check_bit(ack_en, 1'b0);
    end_test("ack_off");
    // Frozen engine must ignore a whole frame on the pin
    clk_en = 1'b0;
    load(OP_LOAD_D, 16'h2468);
    clk_en = 1'b1;
    check_word(d, 16'h7777);
    load(OP_LOAD_D, 16'h2468);
    check_word(d, 16'h2468);
    end_test("freeze");
    complete_run();
  end
endmodule
